// ### rdlfc_top.sv
// Data-link frame controller: frame build, parse, sequence state, Wishbone registers
//
// Chosen here: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`include "rdlfc_defines.svh"
module rdlfc_top (
	input wire logic CLK, // 125 MHz clock
	input wire logic RESET, // Asynchronous reset, active high
	input wire logic [7:0] ADR_I, // Wishbone byte address
	input wire logic [31:0] DAT_I, // Wishbone write data
	output logic [31:0] DAT_O, // Wishbone read data
	input wire logic WE_I, // Wishbone write enable
	input wire logic [3:0] SEL_I, // Wishbone byte selects
	input wire logic CYC_I, // Wishbone cycle
	input wire logic STB_I, // Wishbone strobe
	output logic ACK_O, // Wishbone acknowledge
	output logic TX_VALID, // Outgoing block valid
	input wire logic TX_READY, // Link takes outgoing block
	output logic [47:0] TX_BLOCK, // Outgoing block
	output logic TX_LAST, // Last block of frame
	input wire logic DIN_VALID, // Payload block offered
	output logic DIN_READY, // Payload block taken
	input wire logic [47:0] DIN_BLOCK, // Payload block
	input wire logic RX_VALID, // Incoming block valid
	input wire logic [47:0] RX_BLOCK, // Incoming block
	input wire logic RX_LAST, // Last block of incoming frame
	input wire logic RX_ERR, // Frame damaged, with RX_LAST
	output logic RXD_VALID, // Delivered payload block valid
	output logic [47:0] RXD_BLOCK, // Delivered payload block
	output logic RXD_LAST // Last delivered block of frame
);
	import rdlfc_pkg::*;

	rdlfc_st_t q;
	rdlfc_st_t n;
	rdlfc_hdr_if hif ();

	rdlfc_ctl_dec u_dec (
		.h(hif.dec)
	);

	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		for (int i = 0; i < 4; i++) begin
			lane_mask[i*8 +: 8] = {8{sel[i]}};
		end
	endfunction : lane_mask

	logic [31:0] wmask;
	logic wr;
	logic rd;
	logic slot_free;
	logic [31:0] cmd;
	logic [7:0] cmd_control_field;
	logic cmd_i;
	logic cmd_num;
	logic cmd_cr;
	logic cmd_pf;
	logic cmd_xtra;
	logic [6:0] cmd_ndat;
	logic [6:0] maxb;
	logic refuse;
	logic [7:0] control_field_out;
	logic rx_end;
	logic rx_num;
	logic rx_apply;

	always_comb begin
		hif.blk = (q.rx_st == RX_CTL) ? RX_BLOCK : q.rx_hdr;
		hif.own = q.ctrl[`RDLFC_F_OWN];
		hif.gadr = q.grp[`RDLFC_F_GADR];
		hif.gen = q.grp[`RDLFC_F_GEN];
		hif.vs = q.vs;
		hif.va = q.va;
	end

	always_comb begin
		n = q;
		wmask = lane_mask(SEL_I);
		wr = CYC_I && STB_I && !q.ack && WE_I;
		rd = CYC_I && STB_I && !q.ack && !WE_I;
		n.ack = CYC_I && STB_I && !q.ack;
		n.dat = 32'h0;
		n.tx_vld = q.tx_vld && !TX_READY;
		slot_free = !q.tx_vld || TX_READY;
		n.rxd_vld = 1'b0;
		n.rxd_last = 1'b0;

		// Clamp the data-block limit at 64
		maxb = (q.ctrl[`RDLFC_F_MAXB] > `RDLFC_MAXB_CAP) ? `RDLFC_MAXB_CAP :
			q.ctrl[`RDLFC_F_MAXB];

		// Command decode for a TXCMD write
		cmd = (q.txcmd & ~wmask) | (DAT_I & wmask);
		cmd_i = !cmd[0];
		cmd_num = cmd_i || (cmd[`RDLFC_C_KIND] == `RDLFC_KIND_S);
		cmd_ndat = cmd[`RDLFC_F_NDAT];
		cmd_cr = cmd_i ? 1'b1 : cmd[`RDLFC_F_CR];
		// A response carries final exactly when a poll is waiting for it
		cmd_pf = cmd_cr ? cmd[`RDLFC_F_PF] : q.fpend;
		cmd_xtra = cmd[`RDLFC_F_XTRA] && !cmd_i && (cmd_ndat == 7'h0);
		cmd_control_field = cmd[`RDLFC_F_CONTROL_FIELD];
		if (cmd_i) begin
			control_field_out = {q.vr, cmd_pf, q.vs, 1'b0};
		end else if (cmd_num) begin
			control_field_out = {q.vr, cmd_pf, cmd_control_field[3:0]};
		end else begin
			control_field_out = {cmd_control_field[7:5], cmd_pf, cmd_control_field[3:0]};
		end
		refuse = (q.tx_st != TX_IDLE) ||
			(q.ctrl[`RDLFC_F_MODE] == `RDLFC_MODE_DISC && cmd_num) ||
			(q.ctrl[`RDLFC_F_MODE] == `RDLFC_MODE_GRP && !q.ctrl[`RDLFC_F_INIT] &&
				cmd_ndat != 7'h0) ||
			(cmd_ndat > maxb) ||
			(cmd_i && cmd_ndat == 7'h0) ||
			(cmd_i && rdlfc_dist(q.vs, q.va) >= q.ctrl[`RDLFC_F_K]) ||
			(cmd_cr && cmd_pf && q.pout);

		// Register writes; sticky status bits clear on a written one
		if (wr) begin
			case (ADR_I)
				`RDLFC_REG_CTRL: n.ctrl = (q.ctrl & ~wmask) | (DAT_I & wmask);
				`RDLFC_REG_GROUP: n.grp = (q.grp & ~wmask[7:0]) | (DAT_I[7:0] & wmask[7:0]);
				`RDLFC_REG_TXPAR: n.txpar = (q.txpar & ~wmask) | (DAT_I & wmask);
				`RDLFC_REG_TXCMD: begin
					if (refuse) begin
						n.refu = 1'b1;
					end else begin
						n.txcmd = {7'h0, cmd_xtra, cmd_ndat, cmd_pf, cmd_cr,
							cmd[`RDLFC_F_DEST], control_field_out};
						n.tx_left = cmd_ndat;
						n.tx_st = TX_ADDR;
						if (cmd_i) begin
							n.vs = q.vs + `RDLFC_SEQ_ONE;
						end
						if (cmd_cr && cmd_pf) begin
							n.pout = 1'b1;
						end
						if (!cmd_cr && cmd_pf) begin
							n.fpend = 1'b0;
						end
					end
				end
				`RDLFC_REG_STAT: begin
					n.perr = q.perr && !DAT_I[12];
					n.refu = q.refu && !DAT_I[13];
					n.retx = q.retx && !DAT_I[14];
				end
				default: begin
				end
			endcase
		end

		// Read data; reading RXHDR retires the fresh flag
		if (rd) begin
			case (ADR_I)
				`RDLFC_REG_CTRL: n.dat = q.ctrl;
				`RDLFC_REG_GROUP: n.dat = {24'h0, q.grp};
				`RDLFC_REG_TXPAR: n.dat = q.txpar;
				`RDLFC_REG_TXCMD: n.dat = q.txcmd;
				`RDLFC_REG_STAT: n.dat = {17'h0, q.retx, q.refu, q.perr, q.pout, q.fpend,
					q.tx_st != TX_IDLE, q.va, q.vr, q.vs};
				`RDLFC_REG_RXPAR: n.dat = q.rx_hdr[`RDLFC_B_PAR];
				`RDLFC_REG_RXHDR: begin
					n.dat = {15'h0, q.rx_fresh, q.rx_hdr[15:0]};
					n.rx_fresh = 1'b0;
				end
				default: n.dat = 32'h0;
			endcase
		end

		// Transmit sequencer: address, control, optional extra control, payload
		case (q.tx_st)
			TX_ADDR: begin
				if (slot_free) begin
					n.tx_vld = 1'b1;
					n.tx_blk = {42'h0, `RDLFC_OPCODE};
					n.tx_last = 1'b0;
					n.tx_st = TX_CTL;
				end
			end
			TX_CTL: begin
				if (slot_free) begin
					n.tx_vld = 1'b1;
					n.tx_blk = {q.txpar, q.txcmd[`RDLFC_F_DEST], q.txcmd[`RDLFC_F_CR],
						q.txcmd[`RDLFC_F_CONTROL_FIELD]};
					n.tx_last = (q.tx_left == 7'h0) && !q.txcmd[`RDLFC_F_XTRA];
					if (q.txcmd[`RDLFC_F_XTRA]) begin
						n.tx_st = TX_XTRA;
					end else if (q.tx_left != 7'h0) begin
						n.tx_st = TX_DATA;
					end else begin
						n.tx_st = TX_IDLE;
					end
				end
			end
			TX_XTRA, TX_DATA: begin
				if (DIN_VALID && q.din_rdy) begin
					n.tx_vld = 1'b1;
					n.tx_blk = DIN_BLOCK;
					n.tx_last = (q.tx_st == TX_XTRA) || (q.tx_left == 7'h1);
					if (q.tx_st == TX_DATA) begin
						n.tx_left = q.tx_left - 7'h1;
					end
					if (n.tx_last) begin
						n.tx_st = TX_IDLE;
					end
				end
			end
			default: begin
			end
		endcase
		n.din_rdy = ((n.tx_st == TX_XTRA) || (n.tx_st == TX_DATA)) && !n.tx_vld;

		// Receive parser
		rx_end = 1'b0;
		rx_num = (hif.fmt != FMT_U);
		rx_apply = 1'b0;
		if (RX_VALID) begin
			case (q.rx_st)
				RX_ADDR: begin
					if (!RX_LAST) begin
						n.rx_st = (RX_BLOCK[`RDLFC_B_OPC] == `RDLFC_OPCODE) ? RX_CTL : RX_SKIP;
					end
				end
				RX_CTL: begin
					n.rx_hdr = RX_BLOCK;
					n.rx_keep = hif.hit && !(q.ctrl[`RDLFC_F_MODE] == `RDLFC_MODE_DISC &&
						rx_num);
					rx_end = RX_LAST;
					n.rx_st = RX_LAST ? RX_ADDR : RX_DATA;
				end
				RX_DATA: begin
					n.rxd_vld = q.rx_keep;
					n.rxd_blk = RX_BLOCK;
					n.rxd_last = RX_LAST && q.rx_keep;
					rx_end = RX_LAST;
					if (RX_LAST) begin
						n.rx_st = RX_ADDR;
					end
				end
				default: begin
					if (RX_LAST) begin
						n.rx_st = RX_ADDR;
					end
				end
			endcase
		end
		rx_apply = rx_end && !RX_ERR && hif.hit &&
			!(q.ctrl[`RDLFC_F_MODE] == `RDLFC_MODE_DISC && rx_num);
		if (rx_apply) begin
			n.rx_fresh = 1'b1;
			if (hif.fmt == FMT_I && !hif.cr) begin
				n.perr = 1'b1;
			end else begin
				if (hif.fmt == FMT_I && hif.ns == q.vr) begin
					n.vr = q.vr + `RDLFC_SEQ_ONE;
				end
				if (rx_num) begin
					if (hif.nr_ok) begin
						n.va = hif.nr;
					end else begin
						n.perr = 1'b1;
					end
				end
				if (hif.cr && hif.pf) begin
					n.fpend = 1'b1;
				end
				if (!hif.cr && hif.pf) begin
					n.pout = 1'b0;
					if (rx_num && hif.nr != q.vs) begin
						n.retx = 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			q <= '0;
			q.ctrl <= `RDLFC_CTRL_RST;
			q.tx_st <= TX_IDLE;
			q.rx_st <= RX_ADDR;
		end else begin
			q <= n;
		end
	end

	always_comb begin
		ACK_O = q.ack;
		DAT_O = q.dat;
		TX_VALID = q.tx_vld;
		TX_BLOCK = q.tx_blk;
		TX_LAST = q.tx_last;
		DIN_READY = q.din_rdy;
		RXD_VALID = q.rxd_vld;
		RXD_BLOCK = q.rxd_blk;
		RXD_LAST = q.rxd_last;
	end
endmodule : rdlfc_top

// ### rdlfc_defines.svh
// Register map, field positions, codes and reset values of the frame controller
// What this block does
// - In balanced mode either station starts, cancels or ends transfers with one command set.
// - In group mode only the initiating station sends data packets.
// - Disconnected mode neither sends nor accepts numbered command or response frames.
// - Each transmission opens with an address block carrying code 011010, then a control block.
// - A control packet may carry one extra control block after the first.
// - Data blocks per packet never exceed the run-time maximum, itself at most 64.
// - Control block holds 32-bit parameter, 7-bit sub-address, command flag, 8-bit control field.
// - Sub-addresses 1..126 are terminals, 0 matches nobody, 127 reaches every terminal.
// - A terminal accepts its own sub-address and its assigned group sub-address.
// - Sub-address is exactly seven bits; no bit ever extends it.
// - Command flag is 1 for commands, 0 for responses; received frames classified by it.
// - Control field leading 0 is information, 10 supervisory, 11 unnumbered; all carry poll/final.
// - Sequence numbers and state variables are 3 bits and wrap modulo 8.
// - An in-sequence information frame takes its send number from the send state.
// - Information and supervisory frames sent carry the receive state as receive number.
// - Send state steps once per information frame and stays within window K (1..7).
// - Receive state steps only for a good frame whose send number equals it.
// - A valid received receive number is loaded into the acknowledge state.
// - Poll/final is poll in commands, final in responses; poll asks for final.
// - After a poll command the next response sent carries final set.
// - One poll outstanding per direction; final only once per received poll.
// - Receive number in a final response is checked for needed retransmission.
// - Unnumbered information goes without recovery, flow control or acknowledgement.
// - Information frames are always commands and carry 1..maximum data blocks.
`ifndef RDLFC_DEFINES_SVH
`define RDLFC_DEFINES_SVH
`define RDLFC_OPCODE 6'h1a
`define RDLFC_REG_CTRL 8'h00
`define RDLFC_REG_GROUP 8'h04
`define RDLFC_REG_TXPAR 8'h08
`define RDLFC_REG_TXCMD 8'h0c
`define RDLFC_REG_STAT 8'h10
`define RDLFC_REG_RXPAR 8'h14
`define RDLFC_REG_RXHDR 8'h18
`define RDLFC_CTRL_RST 32'h0000_3038
`define RDLFC_F_MODE 1:0
`define RDLFC_F_INIT 2
`define RDLFC_F_K 5:3
`define RDLFC_F_MAXB 12:6
`define RDLFC_F_OWN 19:13
`define RDLFC_F_GADR 6:0
`define RDLFC_F_GEN 7
`define RDLFC_F_CONTROL_FIELD 7:0
`define RDLFC_F_DEST 14:8
`define RDLFC_F_CR 15
`define RDLFC_F_PF 16
`define RDLFC_F_NDAT 23:17
`define RDLFC_F_XTRA 24
`define RDLFC_MODE_DISC 2'h0
`define RDLFC_MODE_BAL 2'h1
`define RDLFC_MODE_GRP 2'h2
`define RDLFC_MAXB_CAP 7'h40
`define RDLFC_C_NS 3:1
`define RDLFC_C_PF 4
`define RDLFC_C_NR 7:5
`define RDLFC_C_SFN 3:2
`define RDLFC_C_KIND 1:0
`define RDLFC_KIND_S 2'h1
`define RDLFC_B_PAR 47:16
`define RDLFC_B_ADR 15:9
`define RDLFC_B_CR 8
`define RDLFC_B_CONTROL_FIELD 7:0
`define RDLFC_B_OPC 5:0
`define RDLFC_ADR_NONE 7'h00
`define RDLFC_ADR_ALL 7'h7f
`define RDLFC_SEQ_ONE 3'h1
`endif

// ### rdlfc_pkg.sv
// Types shared by the frame controller modules
package rdlfc_pkg;
	typedef enum logic [2:0] {TX_IDLE, TX_ADDR, TX_CTL, TX_XTRA, TX_DATA} rdlfc_tx_t;
	typedef enum logic [1:0] {RX_ADDR, RX_CTL, RX_DATA, RX_SKIP} rdlfc_rx_t;
	typedef enum logic [1:0] {FMT_I, FMT_S, FMT_U} rdlfc_fmt_t;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
		logic [31:0] ctrl;
		logic [7:0] grp;
		logic [31:0] txpar;
		logic [31:0] txcmd;
		logic [2:0] vs;
		logic [2:0] vr;
		logic [2:0] va;
		logic fpend;
		logic pout;
		logic perr;
		logic refu;
		logic retx;
		rdlfc_tx_t tx_st;
		logic [6:0] tx_left;
		logic tx_vld;
		logic [47:0] tx_blk;
		logic tx_last;
		logic din_rdy;
		rdlfc_rx_t rx_st;
		logic rx_keep;
		logic [47:0] rx_hdr;
		logic rx_fresh;
		logic rxd_vld;
		logic [47:0] rxd_blk;
		logic rxd_last;
	} rdlfc_st_t;

	// Modulo-8 distance from b forward to a
	function automatic logic [2:0] rdlfc_dist(input logic [2:0] a, input logic [2:0] b);
		rdlfc_dist = a - b;
	endfunction : rdlfc_dist
endpackage : rdlfc_pkg

// ### rdlfc_hdr_if.sv
// Control block decode bundle between the core and the decoder
`timescale 1ns/1ps
interface rdlfc_hdr_if;
	logic [47:0] blk;
	logic [6:0] own;
	logic [6:0] gadr;
	logic gen;
	logic [2:0] vs;
	logic [2:0] va;
	rdlfc_pkg::rdlfc_fmt_t fmt;
	logic cr;
	logic pf;
	logic [2:0] ns;
	logic [2:0] nr;
	logic hit;
	logic nr_ok;
	modport dec (input blk, own, gadr, gen, vs, va, output fmt, cr, pf, ns, nr, hit, nr_ok);
	modport core (output blk, own, gadr, gen, vs, va, input fmt, cr, pf, ns, nr, hit, nr_ok);
endinterface : rdlfc_hdr_if

// ### rdlfc_ctl_dec.sv
// Decoder for a received control block
`timescale 1ns/1ps
`include "rdlfc_defines.svh"
module rdlfc_ctl_dec (
	rdlfc_hdr_if.dec h // Control block and station context
);
	import rdlfc_pkg::*;

	logic [7:0] control_field;
	logic [6:0] adr;

	always_comb begin
		control_field = h.blk[`RDLFC_B_CONTROL_FIELD];
		adr = h.blk[`RDLFC_B_ADR];
		h.cr = h.blk[`RDLFC_B_CR];
		h.pf = control_field[`RDLFC_C_PF];
		h.ns = control_field[`RDLFC_C_NS];
		h.nr = control_field[`RDLFC_C_NR];
		if (!control_field[0]) begin
			h.fmt = FMT_I;
		end else if (control_field[`RDLFC_C_KIND] == `RDLFC_KIND_S) begin
			h.fmt = FMT_S;
		end else begin
			h.fmt = FMT_U;
		end
		// Address zero never matches, not even a register left at zero
		h.hit = (adr != `RDLFC_ADR_NONE) && ((adr == `RDLFC_ADR_ALL) || (adr == h.own) ||
			(h.gen && adr == h.gadr));
		h.nr_ok = rdlfc_dist(h.nr, h.va) <= rdlfc_dist(h.vs, h.va);
	end
endmodule : rdlfc_ctl_dec

// ### rdlfc_top_assertions.sv
// Concurrent checks on the frame controller ports
`timescale 1ns/1ps
`include "rdlfc_defines.svh"
module rdlfc_top_assertions (
	input wire logic CLK, // Clock
	input wire logic RESET, // Reset
	input wire logic CYC_I, // Bus cycle
	input wire logic STB_I, // Bus strobe
	input wire logic ACK_O, // Bus acknowledge
	input wire logic [31:0] DAT_O, // Read data
	input wire logic TX_VALID, // Outgoing valid
	input wire logic TX_READY, // Outgoing taken
	input wire logic [47:0] TX_BLOCK, // Outgoing block
	input wire logic TX_LAST, // Outgoing last
	input wire logic DIN_VALID, // Payload offered
	input wire logic DIN_READY, // Payload taken
	input wire logic RX_VALID, // Incoming valid
	input wire logic RXD_VALID, // Delivered valid
	input wire logic RXD_LAST // Delivered last
);
	logic [1:0] idx_q;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);
	// Position of the next outgoing block within its frame
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			idx_q <= 2'h0;
		end else if (TX_VALID && TX_READY) begin
			idx_q <= TX_LAST ? 2'h0 : ((idx_q == 2'h3) ? idx_q : idx_q + 2'h1);
		end
	end
	AST_ACK_ANSWER: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
		else $error("request not acknowledged next cycle");
	AST_ACK_ONE: assert property (ACK_O |=> !ACK_O)
		else $error("ack longer than one cycle");
	AST_ACK_CAUSE: assert property ($rose(ACK_O) |-> $past(CYC_I && STB_I))
		else $error("ack without request");
	AST_DAT_IDLE: assert property (!ACK_O |-> DAT_O == 32'h0)
		else $error("read data outside ack");
	AST_TX_HOLD: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_BLOCK)
		&& $stable(TX_LAST)) else $error("outgoing block changed before taken");
	AST_ADDR_BLK: assert property (TX_VALID && idx_q == 2'h0 |-> TX_BLOCK == {42'h0, `RDLFC_OPCODE})
		else $error("frame does not open with address block");
	AST_I_CMD: assert property (TX_VALID && idx_q == 2'h1 && !TX_BLOCK[0] |-> TX_BLOCK[8] && !TX_LAST)
		else $error("information frame not a command with data");
	AST_DIN_ONE: assert property (DIN_VALID && DIN_READY |=> !DIN_READY)
		else $error("payload ready held after take");
	AST_RXD_CAUSE: assert property (RXD_VALID |-> $past(RX_VALID))
		else $error("delivery without incoming block");
	AST_RXD_LAST: assert property (RXD_LAST |-> RXD_VALID)
		else $error("delivered last without valid");
	COV_TX_END: cover property (TX_VALID && TX_READY && TX_LAST);
	COV_TX_STALL: cover property (TX_VALID && !TX_READY);
	COV_RXD_END: cover property (RXD_VALID && RXD_LAST);
endmodule : rdlfc_top_assertions

// ### rdlfc_peer.sv
// Remote station model: takes outgoing blocks, sends incoming frames
`timescale 1ns/1ps
`include "rdlfc_defines.svh"
module rdlfc_peer (
	input wire logic clk, // Clock
	input wire logic tx_valid, // Outgoing valid
	input wire logic [47:0] tx_block, // Outgoing block
	output logic tx_ready, // Takes outgoing block
	output logic rx_valid, // Incoming valid
	output logic [47:0] rx_block, // Incoming block
	output logic rx_last, // Last incoming block
	output logic rx_err // Damaged frame
);
	logic slow;
	logic [47:0] txq [$];
	initial begin
		slow = 1'b0;
		tx_ready = 1'b0;
		rx_valid = 1'b0;
		rx_block = 48'h0;
		rx_last = 1'b0;
		rx_err = 1'b0;
	end
	// Slow mode stalls every other cycle
	always @(posedge clk) begin
		tx_ready <= slow ? ~tx_ready : 1'b1;
		if (tx_valid && tx_ready) begin
			txq.push_back(tx_block);
		end
	end
	task send(input logic [47:0] ctl, input logic [47:0] dat, input logic hd, input logic err);
		@(posedge clk);
		rx_valid <= 1'b1;
		rx_block <= {42'h0, `RDLFC_OPCODE};
		@(posedge clk);
		rx_block <= ctl;
		rx_last <= !hd;
		rx_err <= !hd && err;
		if (hd) begin
			@(posedge clk);
			rx_block <= dat;
			rx_last <= 1'b1;
			rx_err <= err;
		end
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_last <= 1'b0;
		rx_err <= 1'b0;
		rx_block <= ~rx_block;
		repeat (3) @(posedge clk);
	endtask : send
endmodule : rdlfc_peer

// ### rdlfc_top_tb_top.sv
// Self-checking bench for the frame controller
`timescale 1ns/1ps
`include "rdlfc_defines.svh"
module rdlfc_top_tb_top;
	localparam logic [31:0] PAR = 32'h1234_5678;
	localparam logic [47:0] DINV = 48'hbeef_0000_0001;
	localparam logic [47:0] RDAT = 48'h0123_4567_89ab;
	logic clk, rst, cyc, stb, we, ack, din_valid, din_ready, tx_valid, tx_ready, tx_last;
	logic rx_valid, rx_last, rx_err, rxd_valid, rxd_last;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, dat_o, rd;
	logic [47:0] tx_block, din_block, rx_block, rxd_block, rxd_got;
	int fails, samples_checked, rxd_n;
	rdlfc_top rdlfc_top_inst (
		.CLK(clk), .RESET(rst), .ADR_I(adr), .DAT_I(wdat), .DAT_O(dat_o), .WE_I(we), .SEL_I(sel),
		.CYC_I(cyc), .STB_I(stb), .ACK_O(ack), .TX_VALID(tx_valid), .TX_READY(tx_ready),
		.TX_BLOCK(tx_block), .TX_LAST(tx_last), .DIN_VALID(din_valid), .DIN_READY(din_ready),
		.DIN_BLOCK(din_block), .RX_VALID(rx_valid), .RX_BLOCK(rx_block), .RX_LAST(rx_last),
		.RX_ERR(rx_err), .RXD_VALID(rxd_valid), .RXD_BLOCK(rxd_block), .RXD_LAST(rxd_last)
	);
	rdlfc_peer rdlfc_peer_inst (
		.clk(clk), .tx_valid(tx_valid), .tx_block(tx_block), .tx_ready(tx_ready),
		.rx_valid(rx_valid), .rx_block(rx_block), .rx_last(rx_last), .rx_err(rx_err)
	);
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		if (rxd_valid === 1'b1) begin
			rxd_got <= rxd_block;
			rxd_n <= rxd_n + 1;
		end
		if (din_valid && din_ready) begin
			din_block <= din_block + 48'h1;
		end
	end
	task print_verdict;
		if (fails == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict
	task cmp32(input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %0t exp %h got %h", $time, e, g);
		end
	endtask : cmp32
	task cmp48(input logic [47:0] e, input logic [47:0] g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %0t exp %h got %h", $time, e, g);
		end
	endtask : cmp48
	// One classic cycle; waits for ack, bounded
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		cmp32(32'h1, {31'h0, ack});
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb
	task rdchk(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		cmp32(e, rd);
	endtask : rdchk
	// Launch a frame and wait until the peer holds n blocks in total
	task launch(input logic [31:0] cmd, input int n);
		int i;
		wb(1'b1, `RDLFC_REG_TXCMD, cmd);
		for (i = 0; i < 300 && rdlfc_peer_inst.txq.size() < n; i++) @(posedge clk);
		if (n > 0) cmp32(n, rdlfc_peer_inst.txq.size());
		repeat (2) @(posedge clk);
	endtask : launch
	initial begin
		#100us;
		cmp32(32'h1, 32'h0);
		print_verdict();
	end
	initial begin
		rst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h0;
		wdat = 32'h0;
		sel = 4'hf;
		din_valid = 1'b1;
		din_block = DINV;
		rxd_got = 48'h0;
		fails = 0;
		samples_checked = 0;
		rxd_n = 0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rdchk(`RDLFC_REG_CTRL, `RDLFC_CTRL_RST);
		rdchk(8'h40, 32'h0);
		launch(32'h0002_8500, 0);
		rdchk(`RDLFC_REG_STAT, 32'h0000_2000);
		wb(1'b1, `RDLFC_REG_STAT, 32'h0000_7000);
		wb(1'b1, `RDLFC_REG_CTRL, 32'h0000_3011);
		wb(1'b1, `RDLFC_REG_TXPAR, PAR);
		rdlfc_peer_inst.slow <= 1'b1;
		launch(32'h0002_8500, 3);
		rdlfc_peer_inst.slow <= 1'b0;
		cmp48({PAR, 16'h0b00}, rdlfc_peer_inst.txq[1]);
		cmp48(DINV, rdlfc_peer_inst.txq[2]);
		launch(32'h0002_8500, 6);
		cmp48({PAR, 16'h0b02}, rdlfc_peer_inst.txq[4]);
		cmp48(DINV + 48'h1, rdlfc_peer_inst.txq[5]);
		launch(32'h0002_8500, 0);
		rdchk(`RDLFC_REG_STAT, 32'h0000_2002);
		wb(1'b1, `RDLFC_REG_STAT, 32'h0000_7000);
		rdlfc_peer_inst.send({32'h0000_00a5, 16'h0350}, RDAT, 1'b1, 1'b0);
		cmp48(RDAT, rxd_got);
		rdchk(`RDLFC_REG_STAT, 32'h0000_048a);
		rdchk(`RDLFC_REG_RXPAR, 32'h0000_00a5);
		launch(32'h0000_0501, 8);
		rdchk(`RDLFC_REG_TXCMD, 32'h0001_0531);
		cmp48({PAR, 16'h0a31}, rdlfc_peer_inst.txq[7]);
		launch(32'h0000_0501, 10);
		rdchk(`RDLFC_REG_TXCMD, 32'h0000_0521);
		rdlfc_peer_inst.send({32'h0, 16'h1342}, RDAT, 1'b1, 1'b0);
		rdlfc_peer_inst.send({32'h0, 16'h0342}, RDAT, 1'b1, 1'b1);
		rdlfc_peer_inst.send({32'h0, 16'hff42}, RDAT, 1'b1, 1'b0);
		rdlfc_peer_inst.send({32'h0, 16'h03a1}, RDAT, 1'b0, 1'b0);
		cmp32(32'h3, rxd_n);
		rdchk(`RDLFC_REG_STAT, 32'h0000_1092);
		wb(1'b1, `RDLFC_REG_CTRL, 32'h0000_3012);
		launch(32'h0002_8500, 0);
		rdchk(`RDLFC_REG_STAT, 32'h0000_3092);
		wb(1'b1, `RDLFC_REG_STAT, 32'h0000_7000);
		launch(32'h0100_8503, 13);
		cmp48({PAR, 16'h0b03}, rdlfc_peer_inst.txq[11]);
		cmp48(DINV + 48'h2, rdlfc_peer_inst.txq[12]);
		launch(32'h0001_8501, 15);
		cmp48({PAR, 16'h0b51}, rdlfc_peer_inst.txq[14]);
		launch(32'h0001_8501, 0);
		rdchk(`RDLFC_REG_STAT, 32'h0000_2892);
		rdlfc_peer_inst.send({32'h0, 16'h0251}, RDAT, 1'b0, 1'b0);
		rdchk(`RDLFC_REG_STAT, 32'h0000_2092);
		print_verdict();
	end
endmodule : rdlfc_top_tb_top
bind rdlfc_top rdlfc_top_assertions rdlfc_top_assertions_inst (.CLK(CLK), .RESET(RESET),
	.CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O), .DAT_O(DAT_O), .TX_VALID(TX_VALID),
	.TX_READY(TX_READY), .TX_BLOCK(TX_BLOCK), .TX_LAST(TX_LAST), .DIN_VALID(DIN_VALID),
	.DIN_READY(DIN_READY), .RX_VALID(RX_VALID), .RXD_VALID(RXD_VALID), .RXD_LAST(RXD_LAST));
